/* core/activity_detect.sv */
// activity_detect: flags a sync line active while edges keep arriving
// assumes the sync input is synchronous to clock_in
`timescale 1ns/1ps
`default_nettype none
module activity_detect #(
  parameter int unsigned WINDOW = sync_proc_pkg::ACT_WINDOW_CYC
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic nrst_in,
  // sync line and activity flag
  input wire logic sync_in,
  output logic active_out
);
  logic last_ff;
  logic nxt_last;
  logic active_ff;
  logic nxt_active;
  logic [sync_proc_pkg::ACT_CNT_W-1:0] cnt_ff;
  logic [sync_proc_pkg::ACT_CNT_W-1:0] nxt_cnt;
  localparam logic [sync_proc_pkg::ACT_CNT_W-1:0] WIN_LAST = sync_proc_pkg::ACT_CNT_W'(WINDOW - 1);
  logic edge_seen;

  always_comb begin
    edge_seen = sync_in ^ last_ff;
    nxt_last = sync_in;
    nxt_cnt = cnt_ff;
    nxt_active = active_ff;
    if (edge_seen) begin
      nxt_cnt = '0;
      nxt_active = 1'b1;
    end else if (cnt_ff == WIN_LAST) begin
      nxt_active = 1'b0;
    end else begin
      nxt_cnt = cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      last_ff <= 1'b0;
      cnt_ff <= '0;
      active_ff <= 1'b0;
    end else begin
      last_ff <= nxt_last;
      cnt_ff <= nxt_cnt;
      active_ff <= nxt_active;
    end
  end

  assign active_out = active_ff;

  a_edge_sets_active: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (sync_in != last_ff) |=> active_ff) else $error("edge did not set activity");
endmodule : activity_detect
`default_nettype wire

/* core/sync_input_processor.sv */
// sync_input_processor: sync activity, source selection, separation, slicer settings
// assumes inputs synchronous to clock_in; comparator result arrives as sog_cmp_in
`timescale 1ns/1ps
`default_nettype none
// Operation
// - two hsync and three sync-on-green inputs; pll source chosen from activity
// - slicer threshold programmable at subaddress 10h
// - five-bit threshold code, reset 11; level is 350 mV times code over 31
// - sliced composite sync drives a dedicated output pin
// - low-pass cutoff 2.5, 10 or 33 MHz; bypassed after reset
// - vertical and horizontal sync separated from sliced sync-on-green
// - separator handles field rates of 40 Hz or more only
// - hsync and vsync activity flags read from status at 14h
// - auto with both inputs active uses separate hsync and vsync
// - auto with only hsync active treats it as composite sync
// - composite sync is v xor h by default, or v or h
// - auto with neither input active selects sync-on-green
module sync_input_processor (
  // clock and reset
  input wire logic clock_in,
  input wire logic nrst_in,
  // register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  // sync pins
  input wire logic [1:0] hsync_in,
  input wire logic vsync_in,
  input wire logic [2:0] sog_cmp_in,
  // slicer and filter controls to the analog front end
  output logic [4:0] slice_threshold_code_out,
  output logic [1:0] sog_filter_out,
  // sync outputs
  output logic sliced_sync_output_out,
  output logic pll_hsync_out,
  output logic active_vsync_out,
  // interrupt
  output logic irq_out
);
  logic [4:0] slice_ff, nxt_slice;
  logic [7:0] sel_ff, nxt_sel;
  logic [1:0] filt_ff, nxt_filt;
  logic [2:0] irq_stat_ff, nxt_irq_stat;
  logic [2:0] irq_mask_ff, nxt_irq_mask;
  logic [7:0] rdata_ff, nxt_rdata;
  logic irq_ff, nxt_irq;
  logic [2:0] act_prev_ff, nxt_act_prev;
  logic sliced_ff, nxt_sliced;
  logic hs_ff, nxt_hs;
  logic vs_ff, nxt_vs;
  logic csync_last_ff, nxt_csync_last;
  logic [sync_proc_pkg::SEP_CNT_W-1:0] low_cnt_ff, nxt_low_cnt;
  logic sep_v_ff, nxt_sep_v;
  sync_proc_pkg::src_sel_t src_ff, nxt_src;

  logic [1:0] h_act;
  logic v_act;
  logic [2:0] sog_act;
  logic [2:0] act_now;
  logic h_sel_act;
  logic sog_sel;
  logic h_pin;
  logic csync;
  localparam logic [sync_proc_pkg::SEP_CNT_W-1:0] VSEP_LIMIT =
    sync_proc_pkg::SEP_CNT_W'(sync_proc_pkg::VSEP_CYC);

  // activity detectors for both hsync pins, vsync and each sog input
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_hact
      activity_detect u_hact (.clock_in(clock_in), .nrst_in(nrst_in), .sync_in(hsync_in[gi]),
        .active_out(h_act[gi]));
    end
    for (gi = 0; gi < 3; gi++) begin : g_sact
      activity_detect u_sact (.clock_in(clock_in), .nrst_in(nrst_in), .sync_in(sog_cmp_in[gi]),
        .active_out(sog_act[gi]));
    end
  endgenerate
  activity_detect u_vact (.clock_in(clock_in), .nrst_in(nrst_in), .sync_in(vsync_in),
    .active_out(v_act));

  // picks one of three sog lines by a two-bit code
  function automatic logic pick_sog(input logic [2:0] lines, input logic [1:0] code);
    logic r;
    r = lines[0];
    if (code == 2'd1) begin
      r = lines[1];
    end else if (code == 2'd2) begin
      r = lines[2];
    end
    return r;
  endfunction : pick_sog

  always_comb begin
    sog_sel = pick_sog(sog_cmp_in, sel_ff[sync_proc_pkg::SEL_SOG_HI:sync_proc_pkg::SEL_SOG_LO]);
    // the active hsync pin is the first one showing activity
    h_pin = h_act[0] ? hsync_in[0] : hsync_in[1];
    h_sel_act = |h_act;
    act_now = {pick_sog(sog_act, sel_ff[sync_proc_pkg::SEL_SOG_HI:sync_proc_pkg::SEL_SOG_LO]), h_sel_act, v_act};
  end

  // source selection, re-evaluated every cycle from the activity flags
  always_comb begin
    nxt_src = src_ff;
    if (h_sel_act && v_act) begin
      nxt_src = sync_proc_pkg::SRC_HSYNC;
    end else if (h_sel_act) begin
      nxt_src = sync_proc_pkg::SRC_CSYNC_H;
    end else begin
      nxt_src = sync_proc_pkg::SRC_SOG;
    end
    // vsync-only is treated like no activity for hsync; it falls to sog since hsync is silent
  end

  // composite sync source and separator
  always_comb begin
    case (src_ff)
      sync_proc_pkg::SRC_HSYNC: csync = h_pin;
      sync_proc_pkg::SRC_CSYNC_H: csync = h_pin;
      sync_proc_pkg::SRC_SOG: csync = sog_sel;
      default: csync = sog_sel;
    endcase
    if (sel_ff[sync_proc_pkg::SEL_HOVR_BIT] && sel_ff[sync_proc_pkg::SEL_HSRC_BIT]) begin
      csync = sog_sel;
    end
    nxt_csync_last = csync;
    nxt_sliced = sog_sel;
    nxt_low_cnt = low_cnt_ff;
    nxt_sep_v = sep_v_ff;
    // broad pulses mark vertical sync; at fields below 40 Hz serration can be missed
    if (csync) begin
      if (low_cnt_ff != VSEP_LIMIT) begin
        nxt_low_cnt = low_cnt_ff + 1'b1;
      end else begin
        nxt_sep_v = 1'b1;
      end
    end else begin
      nxt_low_cnt = '0;
      if (!csync_last_ff) begin
        nxt_sep_v = sep_v_ff;
      end else if (low_cnt_ff != VSEP_LIMIT) begin
        nxt_sep_v = 1'b0;
      end
    end
    // xor coding inverts h during v; or coding forces h low while v is separated
    if (sel_ff[sync_proc_pkg::SEL_CSMODE_BIT]) begin
      nxt_hs = csync & ~sep_v_ff;
    end else begin
      nxt_hs = csync ^ sep_v_ff;
    end
    if (src_ff == sync_proc_pkg::SRC_HSYNC && !sel_ff[sync_proc_pkg::SEL_HOVR_BIT]) begin
      nxt_hs = h_pin;
    end
    nxt_vs = sep_v_ff;
    if (sel_ff[sync_proc_pkg::SEL_VOVR_BIT]) begin
      nxt_vs = sel_ff[sync_proc_pkg::SEL_VSRC_BIT] ? sep_v_ff : vsync_in;
    end else if (src_ff == sync_proc_pkg::SRC_HSYNC) begin
      nxt_vs = vsync_in;
    end
  end

  // register port and interrupt status
  always_comb begin
    nxt_slice = slice_ff;
    nxt_sel = sel_ff;
    nxt_filt = filt_ff;
    nxt_irq_mask = irq_mask_ff;
    nxt_act_prev = act_now;
    nxt_rdata = sync_proc_pkg::ZERO_BYTE;
    nxt_irq_stat = irq_stat_ff;
    if (reg_wr_in) begin
      case (reg_addr_in)
        sync_proc_pkg::SLICE_REG_ADDR: nxt_slice = reg_wdata_in[4:0];
        sync_proc_pkg::SYNC_SEL_REG_ADDR: nxt_sel = reg_wdata_in;
        sync_proc_pkg::FILTER_REG_ADDR: nxt_filt = reg_wdata_in[sync_proc_pkg::FILT_HI:sync_proc_pkg::FILT_LO];
        sync_proc_pkg::IRQ_MASK_ADDR: nxt_irq_mask = reg_wdata_in[2:0];
        default: nxt_slice = slice_ff;
      endcase
    end
    if (reg_rd_in) begin
      case (reg_addr_in)
        sync_proc_pkg::SLICE_REG_ADDR: nxt_rdata = {3'h0, slice_ff};
        sync_proc_pkg::SYNC_SEL_REG_ADDR: nxt_rdata = sel_ff;
        sync_proc_pkg::FILTER_REG_ADDR: nxt_rdata = {6'h00, filt_ff};
        sync_proc_pkg::STATUS_REG_ADDR: nxt_rdata = {5'h00, act_prev_ff};
        sync_proc_pkg::IRQ_STAT_ADDR: begin
          nxt_rdata = {5'h00, irq_stat_ff};
          nxt_irq_stat = sync_proc_pkg::IRQ_RESET;
        end
        sync_proc_pkg::IRQ_MASK_ADDR: nxt_rdata = {5'h00, irq_mask_ff};
        default: nxt_rdata = sync_proc_pkg::ZERO_BYTE;
      endcase
    end
    // set wins over the read clear
    nxt_irq_stat = nxt_irq_stat | (act_now ^ act_prev_ff);
    nxt_irq = |(nxt_irq_stat & irq_mask_ff);
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      slice_ff <= sync_proc_pkg::SLICE_RESET;
      sel_ff <= sync_proc_pkg::SEL_RESET;
      filt_ff <= sync_proc_pkg::FILT_BYPASS;
      irq_stat_ff <= sync_proc_pkg::IRQ_RESET;
      irq_mask_ff <= sync_proc_pkg::IRQ_RESET;
      rdata_ff <= sync_proc_pkg::ZERO_BYTE;
      irq_ff <= 1'b0;
      act_prev_ff <= sync_proc_pkg::IRQ_RESET;
      sliced_ff <= 1'b0;
      hs_ff <= 1'b0;
      vs_ff <= 1'b0;
      csync_last_ff <= 1'b0;
      low_cnt_ff <= '0;
      sep_v_ff <= 1'b0;
      src_ff <= sync_proc_pkg::SRC_SOG;
    end else begin
      slice_ff <= nxt_slice;
      sel_ff <= nxt_sel;
      filt_ff <= nxt_filt;
      irq_stat_ff <= nxt_irq_stat;
      irq_mask_ff <= nxt_irq_mask;
      rdata_ff <= nxt_rdata;
      irq_ff <= nxt_irq;
      act_prev_ff <= nxt_act_prev;
      sliced_ff <= nxt_sliced;
      hs_ff <= nxt_hs;
      vs_ff <= nxt_vs;
      csync_last_ff <= nxt_csync_last;
      low_cnt_ff <= nxt_low_cnt;
      sep_v_ff <= nxt_sep_v;
      src_ff <= nxt_src;
    end
  end

  assign reg_rdata_out = rdata_ff;
  assign slice_threshold_code_out = slice_ff;
  assign sog_filter_out = filt_ff;
  assign sliced_sync_output_out = sliced_ff;
  assign pll_hsync_out = hs_ff;
  assign active_vsync_out = vs_ff;
  assign irq_out = irq_ff;

  sequence s_slice_write;
    reg_wr_in && reg_addr_in == sync_proc_pkg::SLICE_REG_ADDR;
  endsequence
  a_slice_write_lands: assert property (@(posedge clock_in) disable iff (!nrst_in)
    s_slice_write |=> slice_ff == $past(reg_wdata_in[4:0])) else $error("slice code not stored");
  a_slice_reset_val: assert property (@(posedge clock_in)
    !nrst_in |=> slice_ff == sync_proc_pkg::SLICE_RESET || $past(reg_wr_in)) else $error("slice reset value wrong");
  a_sliced_follows: assert property (@(posedge clock_in) disable iff (!nrst_in)
    1'b1 |=> sliced_sync_output_out == $past(sog_sel)) else $error("sliced output stale");
  a_filter_bypass: assert property (@(posedge clock_in)
    $rose(nrst_in) |-> sog_filter_out == sync_proc_pkg::FILT_BYPASS) else $error("filter not bypassed");
  a_status_flags: assert property (@(posedge clock_in) disable iff (!nrst_in)
    reg_rd_in && reg_addr_in == sync_proc_pkg::STATUS_REG_ADDR
    |=> reg_rdata_out[1:0] == $past(act_prev_ff[1:0])) else $error("status flags wrong");
  a_src_both: assert property (@(posedge clock_in) disable iff (!nrst_in)
    h_sel_act && v_act |=> src_ff == sync_proc_pkg::SRC_HSYNC) else $error("separate sync not chosen");
  a_src_csync: assert property (@(posedge clock_in) disable iff (!nrst_in)
    h_sel_act && !v_act |=> src_ff == sync_proc_pkg::SRC_CSYNC_H) else $error("composite not chosen");
  a_src_sog: assert property (@(posedge clock_in) disable iff (!nrst_in)
    !h_sel_act && !v_act |=> src_ff == sync_proc_pkg::SRC_SOG) else $error("sog not chosen");
  a_vovr_wins: assert property (@(posedge clock_in) disable iff (!nrst_in)
    sel_ff[1] && sel_ff[3] |=> active_vsync_out == $past(sep_v_ff)) else $error("override ignored");
  a_irq_level: assert property (@(posedge clock_in) disable iff (!nrst_in)
    1'b1 |=> irq_out == |($past(nxt_irq_stat) & $past(irq_mask_ff))) else $error("irq mismatch");
endmodule : sync_input_processor
`default_nettype wire

/* shared/sync_proc_pkg.sv */
// sync_proc_pkg: register map, field layout, reset values and timing constants
// assumes a plain register port with 8-bit data and 8-bit subaddress
package sync_proc_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  // register subaddresses
  localparam logic [7:0] SLICE_REG_ADDR = 8'h10;
  localparam logic [7:0] STATUS_REG_ADDR = 8'h14;
  localparam logic [7:0] SYNC_SEL_REG_ADDR = 8'h0E;
  localparam logic [7:0] FILTER_REG_ADDR = 8'h1A;
  localparam logic [7:0] IRQ_STAT_ADDR = 8'h30;
  localparam logic [7:0] IRQ_MASK_ADDR = 8'h31;
  // slice threshold field
  localparam int unsigned SLICE_W = 5;
  localparam logic [4:0] SLICE_RESET = 5'h0B;
  // sync select register fields
  localparam int unsigned SEL_HOVR_BIT = 0;
  localparam int unsigned SEL_VOVR_BIT = 1;
  localparam int unsigned SEL_HSRC_BIT = 2;
  localparam int unsigned SEL_VSRC_BIT = 3;
  localparam int unsigned SEL_CSMODE_BIT = 4;
  localparam int unsigned SEL_SOG_LO = 5;
  localparam int unsigned SEL_SOG_HI = 6;
  localparam logic [7:0] SEL_RESET = 8'h00;
  // filter register: cutoff code
  localparam int unsigned FILT_LO = 0;
  localparam int unsigned FILT_HI = 1;
  typedef enum logic [1:0] {
    FILT_BYPASS = 2'b00,
    FILT_2M5 = 2'b01,
    FILT_10M = 2'b10,
    FILT_33M = 2'b11
  } filt_sel_t;
  // status register bits
  localparam int unsigned ST_VACT_BIT = 0;
  localparam int unsigned ST_HACT_BIT = 1;
  localparam int unsigned ST_SOGACT_BIT = 2;
  // interrupt bits: one per activity flag change
  localparam int unsigned IRQ_W = 3;
  localparam logic [2:0] IRQ_RESET = 3'h0;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  // source chosen for the horizontal pll
  typedef enum logic [1:0] {
    SRC_HSYNC = 2'b00,
    SRC_CSYNC_H = 2'b01,
    SRC_SOG = 2'b10
  } src_sel_t;
  // activity window: a 40 Hz field is 25 ms; window covers two slow fields
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned ACT_WINDOW_MS = 50;
  localparam int unsigned ACT_WINDOW_CYC = ACT_WINDOW_MS * 1000 * CLK_MHZ;
  localparam int unsigned ACT_CNT_W = 24;
  // separator: a high pulse longer than this many cycles marks vertical sync
  localparam int unsigned VSEP_PULSE_NS = 8000;
  localparam int unsigned VSEP_CYC = VSEP_PULSE_NS * CLK_MHZ / 1000;
  localparam int unsigned SEP_CNT_W = 16;
endpackage : sync_proc_pkg

/* tb/sync_source_model.sv */
// sync_source_model: behavioural video source driving hsync, vsync and sliced sync-on-green
// assumes the bench starts and stops each pulse train and sets the idle levels
`timescale 1ns/1ps
`default_nettype none
module sync_source_model (
  // clock
  input wire logic clock_in,
  // pulse train enables and idle levels
  input wire logic h_run_in,
  input wire logic v_run_in,
  input wire logic s_run_in,
  input wire logic h_lvl_in,
  input wire logic v_lvl_in,
  input wire logic s_lvl_in,
  // sync lines toward the block
  output logic [1:0] hsync_out,
  output logic vsync_out,
  output logic [2:0] sog_out
);
  logic [8:0] phase_ff = 9'h000;
  always_ff @(posedge clock_in) begin
    phase_ff <= phase_ff + 9'h001;
  end
  // line every 64 cycles; field every 512 cycles, far above the 40 Hz floor
  assign hsync_out = {1'b0, h_run_in ? (phase_ff[5:0] < 6'h04) : h_lvl_in};
  // vsync lead edge offset by 3 cycles so it never coincides with hsync
  assign vsync_out = v_run_in ? (phase_ff >= 9'h003 && phase_ff < 9'h017) : v_lvl_in;
  // only the third sog input carries sync; the others stay at the comparator's low level
  assign sog_out = {s_run_in ? (phase_ff[5:0] < 6'h05) : s_lvl_in, 2'b00};
endmodule : sync_source_model
`default_nettype wire

/* tb/tb.sv */
// tb: register and sync-source tests for sync_input_processor
// assumes the activity window outlasts the run, so flags only ever rise here
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) check(nm, 8'(e), 8'(g));
module tb;
  logic clock_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic h_run = 1'b0, v_run = 1'b0, s_run = 1'b0;
  logic h_lvl = 1'b0, v_lvl = 1'b0, s_lvl = 1'b0;
  logic [7:0] rdata;
  logic [1:0] hsync;
  logic vsync;
  logic [2:0] sog;
  logic [4:0] slice_code;
  logic [1:0] filt;
  logic sliced, pll_h, act_v, irq;
  logic pll_prev = 1'b0;
  int pll_edges = 0;
  int fail_count = 0;
  int checks_done = 0;
  always #2 clock_in = ~clock_in;
  sync_source_model src (.clock_in(clock_in), .h_run_in(h_run), .v_run_in(v_run), .s_run_in(s_run),
    .h_lvl_in(h_lvl), .v_lvl_in(v_lvl), .s_lvl_in(s_lvl), .hsync_out(hsync), .vsync_out(vsync),
    .sog_out(sog));
  sync_input_processor uut (.clock_in(clock_in), .nrst_in(nrst_in), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .hsync_in(hsync),
    .vsync_in(vsync), .sog_cmp_in(sog), .slice_threshold_code_out(slice_code), .sog_filter_out(filt),
    .sliced_sync_output_out(sliced), .pll_hsync_out(pll_h), .active_vsync_out(act_v), .irq_out(irq));
  // counts toggles of the pll sync so a frozen source selection shows up
  always @(posedge clock_in) begin
    pll_prev <= pll_h;
    if (pll_prev !== pll_h) pll_edges <= pll_edges + 1;
  end
  task check(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : check
  task finish_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test
  task wt(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask : wt
  task reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock_in);
    wr <= 1'b0;
  endtask : reg_write
  task rd_chk(input string nm, input logic [7:0] a, input logic [7:0] e);
    @(posedge clock_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock_in);
    rd <= 1'b0;
    #1;
    check(nm, e, rdata);
  endtask : rd_chk
  initial begin
    repeat (20000) @(posedge clock_in);
    fail_count++;
    finish_test();
  end
  initial begin
    wt(10);
    `CHK("slice reset", 8'h0B, slice_code)
    `CHK("filter reset", 8'h00, filt)
    `CHK("outputs reset", 8'h00, {rdata, sliced, pll_h, act_v, irq})
    @(posedge clock_in);
    nrst_in <= 1'b1;
    rd_chk("slice read", sync_proc_pkg::SLICE_REG_ADDR, 8'h0B);
    reg_write(sync_proc_pkg::SLICE_REG_ADDR, 8'hFF);
    wt(2);
    `CHK("slice code", 8'h1F, slice_code)
    rd_chk("slice top", sync_proc_pkg::SLICE_REG_ADDR, 8'h1F);
    reg_write(sync_proc_pkg::SLICE_REG_ADDR, 8'h00);
    rd_chk("slice zero", sync_proc_pkg::SLICE_REG_ADDR, 8'h00);
    for (int i = 3; i >= 0; i--) begin
      reg_write(sync_proc_pkg::FILTER_REG_ADDR, 8'(i));
      wt(2);
      `CHK("filter code", i, filt)
    end
    rd_chk("unmapped", 8'h55, 8'h00);
    rd_chk("status idle", sync_proc_pkg::STATUS_REG_ADDR, 8'h00);
    reg_write(sync_proc_pkg::IRQ_MASK_ADDR, 8'h00);
    reg_write(sync_proc_pkg::SYNC_SEL_REG_ADDR, 8'h40);
    s_run <= 1'b1;
    wt(200);
    s_run <= 1'b0;
    s_lvl <= 1'b1;
    wt(4);
    `CHK("sliced high", 8'h01, sliced)
    `CHK("pll from sog", 8'h01, pll_h)
    s_lvl <= 1'b0;
    wt(4);
    `CHK("sliced low", 8'h00, {sliced, pll_h})
    rd_chk("status sog", sync_proc_pkg::STATUS_REG_ADDR, 8'h04);
    `CHK("irq masked", 8'h00, irq)
    reg_write(sync_proc_pkg::IRQ_MASK_ADDR, 8'h07);
    wt(3);
    `CHK("irq raised", 8'h01, irq)
    rd_chk("irq sog", sync_proc_pkg::IRQ_STAT_ADDR, 8'h04);
    wt(3);
    `CHK("irq cleared", 8'h00, irq)
    rd_chk("irq empty", sync_proc_pkg::IRQ_STAT_ADDR, 8'h00);
    pll_edges = 0;
    h_run <= 1'b1;
    wt(300);
    `CHK("pll from csync", 8'h01, pll_edges > 0)
    `CHK("irq hsync", 8'h01, irq)
    rd_chk("status h", sync_proc_pkg::STATUS_REG_ADDR, 8'h06);
    rd_chk("irq h", sync_proc_pkg::IRQ_STAT_ADDR, 8'h02);
    v_run <= 1'b1;
    wt(1100);
    h_run <= 1'b0;
    v_run <= 1'b0;
    rd_chk("status hv", sync_proc_pkg::STATUS_REG_ADDR, 8'h07);
    rd_chk("irq v", sync_proc_pkg::IRQ_STAT_ADDR, 8'h01);
    h_lvl <= 1'b1;
    v_lvl <= 1'b1;
    wt(4);
    `CHK("pll from hsync", 8'h01, pll_h)
    `CHK("vsync from pin", 8'h01, act_v)
    h_lvl <= 1'b0;
    wt(4);
    `CHK("pll hsync low", 8'h00, pll_h)
    s_lvl <= 1'b1;
    reg_write(sync_proc_pkg::SYNC_SEL_REG_ADDR, 8'h4F);
    wt(4);
    `CHK("override sog", 8'h01, pll_h)
    s_lvl <= 1'b0;
    wt(4);
    `CHK("override sog low", 8'h00, pll_h)
    // a broad pulse longer than the separator limit marks vertical sync
    s_lvl <= 1'b1;
    wt(2010);
    s_lvl <= 1'b0;
    wt(4);
    `CHK("separated vsync", 8'h01, act_v)
    `CHK("xor coding h", 8'h01, pll_h)
    reg_write(sync_proc_pkg::SYNC_SEL_REG_ADDR, 8'h5F);
    wt(4);
    `CHK("or coding h", 8'h00, pll_h)
    reg_write(sync_proc_pkg::SYNC_SEL_REG_ADDR, 8'h50);
    rd_chk("or coding", sync_proc_pkg::SYNC_SEL_REG_ADDR, 8'h50);
    finish_test();
  end
endmodule : tb
`default_nettype wire
